// File: src/axis_status_pkg.sv
// Purpose: constants for the per-axis status, error and interrupt-factor bank
// Assumes: four axes, registers reached over AHB-Lite, one word per register
// Notes: field positions follow the 16-bit register images
// Overview of operation
// - each axis owns finish, error and factor registers; reads follow selected axis
// - finish bit 6 shows constant acceleration phase, bit 7 falling acceleration in S-curve
// - external decel stop halting the drive sets finish bits 11 to 8
// - plus limit halt sets finish bit 12, minus limit halt sets bit 13
// - servo alarm halt sets finish bit 14, emergency halt sets bit 15
// - driving ends on pulses done, stop, soft limit, decel input, limit, alarm, emergency
// - finish and external error bits hold until next drive command or code 25h
// - after driving ends, finish bits 15 to 12 raise the axis error summary
// - any error bit 7 to 0 raises the axis error summary
// - soft bound errors set only in the matching drive direction
// - error bits 2 and 3 follow plus and minus limit inputs
// - error bit 4 follows alarm, bit 5 follows emergency low
// - error bit 7 flags home search failure, index active at step 3
// - error bits 12 to 8 show the home search step code
// - an active hard or soft limit stops driving, decelerating or at once
// - factor bits latch enabled events only; any set factor bit interrupts
// - factor bit 0 drive pulse, bits 1 to 4 compare crossings
// - factor bit 5 constant speed end, bit 6 begin, bit 7 drive end
// - factor bit 8 home search end, bit 9 synchronous action
// - factor read clears the bits and releases the low interrupt output
// - a read touching the low byte clears every factor bit of the selected axis
// - mirror registers show pin levels, first and third axes low byte, second and fourth axes high byte
// - main status bits 7 to 4 carry axis error summaries, fourth axis highest
package axis_status_pkg;
  localparam int NUM_AXES = 4;
  localparam int FACTOR_W = 10;
  // byte addresses
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_FINISH = 8'h04;
  localparam logic [7:0] OFF_ERROR = 8'h08;
  localparam logic [7:0] OFF_FACTOR = 8'h0c;
  localparam logic [7:0] OFF_MIRROR_LO = 8'h10;
  localparam logic [7:0] OFF_MIRROR_HI = 8'h14;
  localparam logic [7:0] OFF_AXIS_SEL = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
  localparam logic [7:0] OFF_STOP_MODE = 8'h20;
  // finish-cause fields
  localparam int FC_ACC_CONST = 6;
  localparam int FC_ACC_FALL = 7;
  localparam int FC_EXT_LO = 8;
  localparam int FC_PLUS_LIM = 12;
  localparam int FC_MINUS_LIM = 13;
  localparam int FC_ALARM = 14;
  localparam int FC_EMG = 15;
  // error register fields
  localparam int ER_SOFT_P = 0;
  localparam int ER_SOFT_M = 1;
  localparam int ER_HARD_P = 2;
  localparam int ER_HARD_M = 3;
  localparam int ER_ALARM = 4;
  localparam int ER_EMG = 5;
  localparam int ER_HOME = 7;
  localparam int ER_STEP_LO = 8;
  localparam int MS_ERR_LO = 4;
  localparam int INDEX_PIN = 2;
  // command codes
  localparam logic [7:0] CMD_DRIVE_FIRST = 8'h20;
  localparam logic [7:0] CMD_DRIVE_LAST = 8'h23;
  localparam logic [7:0] CMD_STOP_CLEAR = 8'h25;
  localparam logic [7:0] CMD_AXIS_SELECT = 8'h0f;
  // reset values
  localparam logic [9:0] IRQ_EN_RESET = 10'h000;
  localparam logic [3:0] STOP_MODE_RESET = 4'h0;
  localparam logic [1:0] AXIS_SEL_RESET = 2'h0;
endpackage

// File: src/ahb_reg_port.sv
// Purpose: AHB-Lite slave front end for the status bank
// Assumes: single slave, zero wait states, OKAY answers only
// Notes: reads are requested in the address phase, writes strobe in the data phase
module ahb_reg_port
  import axis_status_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // handshake answers
  output logic hreadyout,
  output logic hresp,
  // decoded accesses
  output logic rd_req,
  output logic [7:0] rd_addr,
  output logic wr_stb,
  output logic [7:0] wr_addr
);
  import axis_status_pkg::*;

  logic wr_pend;
  logic take;

  assign take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_req = take & ~hwrite;
  assign rd_addr = haddr[7:0];
  assign wr_stb = wr_pend;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= take & hwrite;
      if (take & hwrite)
        wr_addr <= haddr[7:0];
    end
  end
endmodule

// File: src/axis_factor_unit.sv
// Purpose: interrupt-factor flags of one axis
// Assumes: event inputs are synchronous levels or one-cycle pulses
// Notes: edge history resets low, so a level already high after reset is an edge
module axis_factor_unit
  import axis_status_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic [FACTOR_W-1:0] enable,
  input wire logic rd_clear,
  // event sources
  input wire logic drive_pulse,
  input wire logic pos_ge_lower,
  input wire logic pos_ge_upper,
  input wire logic const_speed,
  input wire logic drive_done,
  input wire logic home_done,
  input wire logic sync_event,
  // flags
  output logic [FACTOR_W-1:0] flags
);
  import axis_status_pkg::*;

  logic prev_pulse, prev_lo, prev_up, prev_cs;
  logic [FACTOR_W-1:0] ev;

  always_comb
  begin
    ev[0] = drive_pulse & ~prev_pulse;
    ev[1] = pos_ge_lower & ~prev_lo;
    ev[2] = ~pos_ge_lower & prev_lo;
    ev[3] = ~pos_ge_upper & prev_up;
    ev[4] = pos_ge_upper & ~prev_up;
    ev[5] = ~const_speed & prev_cs;
    ev[6] = const_speed & ~prev_cs;
    ev[7] = drive_done;
    ev[8] = home_done;
    ev[9] = sync_event;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_pulse <= 1'b0;
      prev_lo <= 1'b0;
      prev_up <= 1'b0;
      prev_cs <= 1'b0;
    end
    else
    begin
      prev_pulse <= drive_pulse;
      prev_lo <= pos_ge_lower;
      prev_up <= pos_ge_upper;
      prev_cs <= const_speed;
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags <= '0;
    else
      flags <= (rd_clear ? '0 : flags) | (ev & enable);
  end
endmodule

// File: src/axis_status_bank.sv
// Purpose: per-axis finish cause, error, interrupt factor and pin mirror registers
// Assumes: pins and status inputs are synchronous to hclk
// Notes: axis selection comes from the axis-select command on the command port
module axis_status_bank
  import axis_status_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // command stream
  input wire logic cmd_stb,
  input wire logic [7:0] cmd_code,
  input wire logic [NUM_AXES-1:0] cmd_axes,
  // drive state per axis
  input wire logic [NUM_AXES-1:0] driving,
  input wire logic [NUM_AXES-1:0] drive_minus_dir,
  input wire logic [NUM_AXES-1:0] drive_done,
  input wire logic [NUM_AXES-1:0] drive_pulse,
  input wire logic [NUM_AXES-1:0] const_speed,
  input wire logic [NUM_AXES-1:0] accel_rate_constant_flag,
  input wire logic [NUM_AXES-1:0] accel_rate_falling_flag,
  // comparators per axis
  input wire logic [NUM_AXES-1:0] soft_limit_en,
  input wire logic [NUM_AXES-1:0] pos_ge_upper,
  input wire logic [NUM_AXES-1:0] pos_ge_lower,
  input wire logic [NUM_AXES-1:0] pos_le_lower,
  // pins and their settings
  input wire logic [4*NUM_AXES-1:0] ext_decel_stop_inputs,
  input wire logic [4*NUM_AXES-1:0] ext_decel_enable,
  input wire logic [NUM_AXES-1:0] plus_limit_input,
  input wire logic [NUM_AXES-1:0] minus_limit_input,
  input wire logic [NUM_AXES-1:0] limit_active_high,
  input wire logic [NUM_AXES-1:0] servo_fault_input,
  input wire logic [NUM_AXES-1:0] alarm_enable,
  input wire logic [NUM_AXES-1:0] alarm_active_high,
  input wire logic [NUM_AXES-1:0] jog_plus_input,
  input wire logic [NUM_AXES-1:0] jog_minus_input,
  input wire logic [NUM_AXES-1:0] in_position_input,
  input wire logic emergency_input_low,
  // home search and synchronous action
  input wire logic [5*NUM_AXES-1:0] home_search_step_code,
  input wire logic [NUM_AXES-1:0] home_step3_start,
  input wire logic [NUM_AXES-1:0] home_search_fail,
  input wire logic [NUM_AXES-1:0] home_search_done_event,
  input wire logic [NUM_AXES-1:0] sync_event,
  // outputs to the drive logic and host
  output logic [NUM_AXES-1:0] halt_decel,
  output logic [NUM_AXES-1:0] halt_now,
  output logic [NUM_AXES-1:0] main_status_err,
  output logic irq_out_low
);
  import axis_status_pkg::*;

  function automatic logic [1:0] first_axis(input logic [NUM_AXES-1:0] m);
    logic [1:0] r;
    r = 2'd0;
    for (int i = NUM_AXES - 1; i >= 0; i--)
      if (m[i])
        r = 2'(i);
    return r;
  endfunction

  function automatic logic [15:0] mirror_byte_pair(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo};
  endfunction

  logic rd_req, wr_stb;
  logic [7:0] rd_addr, wr_addr;
  logic [1:0] axis_sel;
  logic [FACTOR_W-1:0] irq_en [NUM_AXES];
  logic [NUM_AXES-1:0] stop_mode;
  logic [15:0] finish [NUM_AXES];
  logic [7:0] err_latch [NUM_AXES];
  logic [7:0] err_bits [NUM_AXES];
  logic [FACTOR_W-1:0] factor [NUM_AXES];
  logic [NUM_AXES-1:0] fac_clear;
  logic [NUM_AXES-1:0] clear_cmd;
  logic [NUM_AXES-1:0] plus_lim, minus_lim, alarm_act, soft_p, soft_m, index_act;
  logic [3:0] decel_act [NUM_AXES];
  logic [7:0] axis_pins [NUM_AXES];
  logic [NUM_AXES-1:0] any_decel, any_factor;
  logic emg_act;
  logic drive_cmd, clr_cmd;
  logic [31:0] next_rdata;

  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_req(rd_req),
    .rd_addr(rd_addr),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr)
  );

  assign drive_cmd = cmd_stb && cmd_code >= CMD_DRIVE_FIRST && cmd_code <= CMD_DRIVE_LAST;
  assign clr_cmd = cmd_stb && cmd_code == CMD_STOP_CLEAR;
  assign clear_cmd = (drive_cmd | clr_cmd) ? cmd_axes : '0;
  assign emg_act = ~emergency_input_low;

  // active-cause decode per axis; external decel and index pins are active low
  always_comb
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      plus_lim[a] = plus_limit_input[a] == limit_active_high[a];
      minus_lim[a] = minus_limit_input[a] == limit_active_high[a];
      alarm_act[a] = alarm_enable[a] & (servo_fault_input[a] == alarm_active_high[a]);
      decel_act[a] = ext_decel_enable[4*a +: 4] & ~ext_decel_stop_inputs[4*a +: 4];
      any_decel[a] = |decel_act[a];
      index_act[a] = ~ext_decel_stop_inputs[4*a + INDEX_PIN];
      soft_p[a] = soft_limit_en[a] & driving[a] & ~drive_minus_dir[a] & pos_ge_upper[a];
      soft_m[a] = soft_limit_en[a] & driving[a] & drive_minus_dir[a] & pos_le_lower[a];
      axis_pins[a] = {servo_fault_input[a], in_position_input[a], jog_minus_input[a],
                      jog_plus_input[a], ext_decel_stop_inputs[4*a +: 4]};
    end
  end

  // stop requests toward the pulse generator
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      halt_decel <= '0;
      halt_now <= '0;
    end
    else
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        // limits stop by the per-axis mode; alarm and emergency always stop at once
        halt_now[a] <= driving[a] & (alarm_act[a] | emg_act |
                       (stop_mode[a] & (plus_lim[a] | minus_lim[a] | soft_p[a] | soft_m[a])));
        halt_decel[a] <= driving[a] & (any_decel[a] |
                         (~stop_mode[a] & (plus_lim[a] | minus_lim[a] | soft_p[a] | soft_m[a])));
      end
    end
  end

  // finish-cause stop bits; a cause seen while driving sticks until cleared
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int a = 0; a < NUM_AXES; a++)
        finish[a] <= 16'h0000;
    end
    else
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        logic [15:0] hold;
        logic [15:0] set;
        hold = clear_cmd[a] ? 16'h0000 : finish[a];
        set = 16'h0000;
        if (driving[a])
        begin
          set[FC_EXT_LO +: 4] = decel_act[a];
          set[FC_PLUS_LIM] = plus_lim[a];
          set[FC_MINUS_LIM] = minus_lim[a];
          set[FC_ALARM] = alarm_act[a];
          set[FC_EMG] = emg_act;
        end
        finish[a] <= hold | set;
      end
    end
  end

  // latched error causes; live levels are merged in err_bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int a = 0; a < NUM_AXES; a++)
        err_latch[a] <= 8'h00;
    end
    else
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        logic [7:0] set;
        set = 8'h00;
        set[ER_SOFT_P] = soft_p[a];
        set[ER_SOFT_M] = soft_m[a];
        set[ER_HARD_P] = driving[a] & plus_lim[a];
        set[ER_HARD_M] = driving[a] & minus_lim[a];
        set[ER_ALARM] = driving[a] & alarm_act[a];
        set[ER_EMG] = driving[a] & emg_act;
        set[ER_HOME] = home_search_fail[a] | (home_step3_start[a] & index_act[a]);
        err_latch[a] <= (clear_cmd[a] ? 8'h00 : err_latch[a]) | set;
      end
    end
  end

  always_comb
  begin
    for (int a = 0; a < NUM_AXES; a++)
    begin
      err_bits[a] = err_latch[a];
      err_bits[a][ER_HARD_P] = err_latch[a][ER_HARD_P] | plus_lim[a];
      err_bits[a][ER_HARD_M] = err_latch[a][ER_HARD_M] | minus_lim[a];
      err_bits[a][ER_ALARM] = err_latch[a][ER_ALARM] | alarm_act[a];
      err_bits[a][ER_EMG] = err_latch[a][ER_EMG] | emg_act;
    end
  end

  // error summary for the main status word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      main_status_err <= '0;
    else
    begin
      for (int a = 0; a < NUM_AXES; a++)
        main_status_err[a] <= (|err_bits[a]) |
                              (~driving[a] & (|finish[a][FC_EMG:FC_PLUS_LIM]));
    end
  end

  // axis selection by command, host-written settings
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      axis_sel <= AXIS_SEL_RESET;
    else if (cmd_stb && cmd_code == CMD_AXIS_SELECT && cmd_axes != '0)
      axis_sel <= first_axis(cmd_axes);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stop_mode <= STOP_MODE_RESET;
      for (int a = 0; a < NUM_AXES; a++)
        irq_en[a] <= IRQ_EN_RESET;
    end
    else if (wr_stb)
    begin
      if (wr_addr == OFF_STOP_MODE)
        stop_mode <= hwdata[NUM_AXES-1:0];
      if (wr_addr == OFF_IRQ_EN)
        irq_en[axis_sel] <= hwdata[FACTOR_W-1:0];
    end
  end

  // interrupt factors, one unit per axis
  for (genvar g = 0; g < NUM_AXES; g++)
  begin : g_fac
    axis_factor_unit u_fac (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(irq_en[g]),
      .rd_clear(fac_clear[g]),
      .drive_pulse(drive_pulse[g]),
      .pos_ge_lower(pos_ge_lower[g]),
      .pos_ge_upper(pos_ge_upper[g]),
      .const_speed(const_speed[g]),
      .drive_done(drive_done[g]),
      .home_done(home_search_done_event[g]),
      .sync_event(sync_event[g]),
      .flags(factor[g])
    );
    assign any_factor[g] = |factor[g];
  end

  // only a read that touches byte lane 0 clears the factors
  always_comb
  begin
    fac_clear = '0;
    if (rd_req && rd_addr[7:2] == OFF_FACTOR[7:2] && rd_addr[1:0] == 2'b00)
      fac_clear[axis_sel] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_out_low <= 1'b1;
    else
      irq_out_low <= ~(|(any_factor & ~fac_clear));
  end

  // read data captured in the address phase, shown in the data phase
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (rd_addr[7:2])
      OFF_MAIN[7:2]:
        next_rdata[7:0] = {main_status_err, driving};
      OFF_FINISH[7:2]:
      begin
        next_rdata[15:0] = finish[axis_sel];
        next_rdata[FC_ACC_CONST] = accel_rate_constant_flag[axis_sel];
        next_rdata[FC_ACC_FALL] = accel_rate_falling_flag[axis_sel];
      end
      OFF_ERROR[7:2]:
        next_rdata[15:0] = {3'b000, home_search_step_code[5*axis_sel +: 5], err_bits[axis_sel]};
      OFF_FACTOR[7:2]:
        next_rdata[FACTOR_W-1:0] = factor[axis_sel];
      OFF_MIRROR_LO[7:2]:
        next_rdata[15:0] = mirror_byte_pair(axis_pins[0], axis_pins[1]);
      OFF_MIRROR_HI[7:2]:
        next_rdata[15:0] = mirror_byte_pair(axis_pins[2], axis_pins[3]);
      OFF_AXIS_SEL[7:2]:
        next_rdata[1:0] = axis_sel;
      OFF_IRQ_EN[7:2]:
        next_rdata[FACTOR_W-1:0] = irq_en[axis_sel];
      OFF_STOP_MODE[7:2]:
        next_rdata[NUM_AXES-1:0] = stop_mode;
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_req)
      hrdata <= next_rdata;
  end

  // hsize is accepted but every read returns the whole word on all lanes
  logic unused_size;
  assign unused_size = ^hsize;
endmodule

// File: bench/axis_status_bank_monitor.sv
// Purpose: checks on stop requests and error summaries of the status bank
// Assumes: limit and alarm level settings stay put while a drive runs
// Notes: stop requests watched on axis 0, emergency summary on every axis
module axis_status_bank_monitor
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // drive state and stop causes
  input wire logic [axis_status_pkg::NUM_AXES-1:0] driving,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] drive_minus_dir,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] soft_limit_en,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] pos_ge_upper,
  input wire logic [4*axis_status_pkg::NUM_AXES-1:0] ext_decel_stop_inputs,
  input wire logic [4*axis_status_pkg::NUM_AXES-1:0] ext_decel_enable,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] plus_limit_input,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] limit_active_high,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] servo_fault_input,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] alarm_enable,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] alarm_active_high,
  input wire logic emergency_input_low,
  // outputs watched
  input wire logic [axis_status_pkg::NUM_AXES-1:0] halt_decel,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] halt_now,
  input wire logic [axis_status_pkg::NUM_AXES-1:0] main_status_err
);
  timeunit 1ns;
  timeprecision 100ps;
  import axis_status_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // either stop flavour counts, for limits the stop mode register picks one
  sequence stops;
    ##[1:2] (halt_decel[0] || halt_now[0]);
  endsequence
  chk_hard_err: assert property (
    plus_limit_input[0] == limit_active_high[0] |-> ##[1:2] main_status_err[0])
    else $error("limit without error summary");
  chk_emg_err: assert property (
    !emergency_input_low |-> ##[1:2] (main_status_err == 4'hf))
    else $error("emergency without error summary");
  chk_halt_driving: assert property (
    (halt_decel[0] || halt_now[0]) |-> $past(driving[0]))
    else $error("stop request while idle");
  chk_limit_halt: assert property (
    driving[0] && plus_limit_input[0] == limit_active_high[0] |-> stops)
    else $error("limit did not stop");
  chk_emg_halt: assert property (
    driving[0] && !emergency_input_low |-> stops)
    else $error("emergency did not stop");
  chk_alarm_halt: assert property (
    driving[0] && alarm_enable[0] && servo_fault_input[0] == alarm_active_high[0] |-> stops)
    else $error("alarm did not stop");
  chk_decel_halt: assert property (
    driving[0] && ext_decel_enable[0] && !ext_decel_stop_inputs[0] |-> stops)
    else $error("decel input did not stop");
  chk_soft_halt: assert property (
    driving[0] && soft_limit_en[0] && pos_ge_upper[0] && !drive_minus_dir[0] |-> stops)
    else $error("soft bound did not stop");
endmodule
bind axis_status_bank axis_status_bank_monitor u_axis_status_bank_monitor (.*);

// File: bench/host_bus_model.sv
// Purpose: host processor issuing single word transfers over AHB-Lite
// Assumes: one slave, its hreadyout is the bus hready
// Notes: a wait past its bound raises timed_out
module host_bus_model
(
  // clock
  input wire logic hclk,
  // bus answers
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // bus requests
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // results
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic timed_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata, rd_valid, rd_data, timed_out} = '0;
    hsize = 3'h2;
  end
  task automatic hold;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 16)
    begin
      @(posedge hclk);
      n++;
    end
    if (n == 16)
      timed_out <= 1'b1;
  endtask
  // phases held until hready is seen, read data taken at the closing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hold();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hold();
    rd_valid <= !w;
    rd_data <= hrdata;
    @(posedge hclk);
    rd_valid <= 1'b0;
  endtask
endmodule

// File: bench/test_axis_status_bank.sv
// Purpose: self-checking bench for the axis status bank
// Assumes: limit and alarm inputs active low throughout
// Notes: expectations are queued, a watcher compares them in order
module test_axis_status_bank;
  timeunit 1ns;
  timeprecision 100ps;
  import axis_status_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cmd_stb, emergency_input_low, irq_out_low;
  logic rd_valid, timed_out, ob_v, ob_d;
  logic [31:0] haddr, hwdata, hrdata, rd_data, got;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] cmd_code;
  logic [3:0] cmd_axes, driving, drive_minus_dir, drive_done, drive_pulse, const_speed, accel_rate_constant_flag;
  logic [3:0] accel_rate_falling_flag, soft_limit_en, pos_ge_upper, pos_ge_lower, pos_le_lower, plus_limit_input;
  logic [3:0] minus_limit_input, limit_active_high, servo_fault_input, alarm_enable, alarm_active_high;
  logic [3:0] jog_plus_input, jog_minus_input, in_position_input, home_step3_start, home_search_fail;
  logic [3:0] home_search_done_event, sync_event, halt_decel, halt_now, main_status_err;
  logic [15:0] ext_decel_stop_inputs, ext_decel_enable;
  logic [19:0] home_search_step_code;
  logic [31:0] exp_q[$];
  logic [31:0] fx[5] = '{32'h0, 32'h8000, 32'h4000, 32'h100, 32'h1000};
  int bt[10] = '{0, 1, 2, 4, 3, 6, 5, 7, 8, 9};
  int n_fail, check_count, seed;
  assign hready = hreadyout;
  axis_status_bank u_axis_status_bank (.*);
  host_bus_model u_host_bus_model (.*);
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic wrap_up;
    if (exp_q.size() != 0)
      n_fail++;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge hclk)
    if (rd_valid || ob_v)
    begin
      got = rd_valid ? rd_data : {31'h0, ob_d};
      check_count++;
      if (got !== exp_q[0])
      begin
        n_fail++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  always @(posedge hclk)
    if (timed_out)
    begin
      n_fail++;
      wrap_up();
    end
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host_bus_model.xfer(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [3:0] m);
    @(posedge hclk);
    cmd_stb <= 1'b1;
    cmd_code <= c;
    cmd_axes <= m;
    @(posedge hclk);
    cmd_stb <= 1'b0;
    @(posedge hclk);
  endtask
  // sampled mid-cycle, once its register has settled
  task automatic irq_is(input logic e);
    exp_q.push_back({31'h0, e});
    @(negedge hclk);
    ob_v <= 1'b1;
    ob_d <= irq_out_low;
    @(negedge hclk);
    ob_v <= 1'b0;
  endtask
  task automatic cause(input int c, input logic on);
    case (c)
      0: {soft_limit_en[0], pos_ge_upper[0]} <= {on, on};
      1: emergency_input_low <= !on;
      2: servo_fault_input[0] <= !on;
      3: ext_decel_stop_inputs[0] <= !on;
      default: plus_limit_input[0] <= !on;
    endcase
  endtask
  task automatic ev(input int k);
    @(posedge hclk);
    case (k)
      0: drive_pulse[0] <= 1'b1;
      1: pos_ge_lower[0] <= 1'b1;
      2: pos_ge_lower[0] <= 1'b0;
      3: pos_ge_upper[0] <= 1'b1;
      4: pos_ge_upper[0] <= 1'b0;
      5: const_speed[0] <= 1'b1;
      6: const_speed[0] <= 1'b0;
      7: drive_done[0] <= 1'b1;
      8: home_search_done_event[0] <= 1'b1;
      default: sync_event[0] <= 1'b1;
    endcase
    @(posedge hclk);
    {drive_pulse, drive_done, home_search_done_event, sync_event} <= '0;
  endtask
  function automatic logic [7:0] mb(input int a);
    return {servo_fault_input[a], in_position_input[a], jog_minus_input[a], jog_plus_input[a],
      ext_decel_stop_inputs[4*a+:4]};
  endfunction
  initial
  begin
    {cmd_stb, cmd_code, cmd_axes, driving, drive_minus_dir, drive_done, drive_pulse, const_speed} = '0;
    {accel_rate_constant_flag, accel_rate_falling_flag, soft_limit_en, pos_ge_upper, pos_ge_lower} = '0;
    {pos_le_lower, limit_active_high, alarm_active_high, jog_plus_input, jog_minus_input} = '0;
    {in_position_input, home_step3_start, home_search_fail, home_search_done_event, sync_event} = '0;
    {ext_decel_enable, n_fail, check_count, ob_v, ob_d, hresetn} = '0;
    {plus_limit_input, minus_limit_input, servo_fault_input, alarm_enable} = '1;
    {ext_decel_stop_inputs, emergency_input_low} = '1;
    home_search_step_code = 20'h00173;
    seed = 32'h0a7c;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_IRQ_EN, 32'h0);
    rd(OFF_AXIS_SEL, 32'h0);
    u_host_bus_model.xfer(1'b1, 8'h40, 32'hffff);
    rd(8'h40, 32'h0);
    alarm_enable <= '0;
    repeat (3)
    begin
      @(posedge hclk);
      {servo_fault_input, in_position_input, jog_minus_input, jog_plus_input} <= 16'($random(seed));
      ext_decel_stop_inputs <= 16'($random(seed));
      @(posedge hclk);
      rd(OFF_MIRROR_LO, {16'h0, mb(1), mb(0)});
      rd(OFF_MIRROR_HI, {16'h0, mb(3), mb(2)});
    end
    @(posedge hclk);
    {servo_fault_input, ext_decel_stop_inputs, alarm_enable} <= '1;
    ext_decel_enable[0] <= 1'b1;
    for (int c = 0; c < 5; c++)
    begin
      cmd(CMD_STOP_CLEAR, 4'h1);
      driving[0] <= 1'b1;
      cause(c, 1'b1);
      repeat (4) @(posedge hclk);
      cause(c, 1'b0);
      driving[0] <= 1'b0;
      repeat (2) @(posedge hclk);
      rd(OFF_FINISH, fx[c]);
    end
    rd(OFF_ERROR, 32'h1304);
    rd(OFF_MAIN, 32'h10);
    {accel_rate_constant_flag[0], accel_rate_falling_flag[0]} <= 2'b11;
    cmd(CMD_STOP_CLEAR, 4'h1);
    rd(OFF_FINISH, 32'hc0);
    rd(OFF_MAIN, 32'h0);
    {accel_rate_constant_flag[0], accel_rate_falling_flag[0]} <= 2'b00;
    ext_decel_stop_inputs[INDEX_PIN] <= 1'b0;
    @(posedge hclk);
    home_step3_start[0] <= 1'b1;
    @(posedge hclk);
    home_step3_start[0] <= 1'b0;
    ext_decel_stop_inputs[INDEX_PIN] <= 1'b1;
    rd(OFF_ERROR, 32'h1380);
    rd(OFF_MAIN, 32'h10);
    cmd(CMD_AXIS_SELECT, 4'b0110);
    rd(OFF_AXIS_SEL, 32'h1);
    rd(OFF_FINISH, 32'h0);
    rd(OFF_ERROR, 32'h0b00);
    cmd(CMD_AXIS_SELECT, 4'h1);
    ev(0);
    repeat (3) @(posedge hclk);
    irq_is(1'b1);
    rd(OFF_FACTOR, 32'h0);
    u_host_bus_model.xfer(1'b1, OFF_IRQ_EN, 32'h3ff);
    rd(OFF_IRQ_EN, 32'h3ff);
    for (int k = 0; k < 10; k++)
    begin
      ev(k);
      repeat (3) @(posedge hclk);
      irq_is(1'b0);
      rd(OFF_FACTOR, 32'h1 << bt[k]);
      irq_is(1'b1);
    end
    repeat (2) @(posedge hclk);
    wrap_up();
  end
  initial
  begin
    repeat (40000) @(posedge hclk);
    n_fail++;
    wrap_up();
  end
endmodule
